// ==== verilog/fiwl_regs.svh ====
`ifndef FIWL_REGS_SVH
`define FIWL_REGS_SVH

// ************************************************************
// register indices (byte address = index * 4)
// ************************************************************
`define FIWL_IDX_STATUS      8'h0C
`define FIWL_IDX_MASK        8'h0D
`define FIWL_IDX_CTRL        8'h0E
`define FIWL_IDX_PSTATE      8'h0F
`define FIWL_IDX_KEY         8'h10

// ************************************************************
// status, mask and control bit positions
// ************************************************************
`define FIWL_BIT_LED_OVP     7
`define FIWL_BIT_RAIL6       6
`define FIWL_BIT_PROJ_REQ    5
`define FIWL_BIT_MIRROR_FLT  4
`define FIWL_BIT_BATT_UV     3
`define FIWL_BIT_BATT_WEAK   2
`define FIWL_BIT_THERM_SD    1
`define FIWL_BIT_THERM_WARN  0
`define FIWL_BIT_MIRROR_EN   0

// ************************************************************
// key values and readback
// ************************************************************
`define FIWL_KEY_FIRST       8'hBA
`define FIWL_KEY_SECOND      8'hBE
`define FIWL_KEY_LOCK        8'h00
`define FIWL_KEY_RD_LOCKED   8'h00
`define FIWL_KEY_RD_UNLOCKED 8'h01

// ************************************************************
// reset values
// ************************************************************
`define FIWL_RST_MASK        8'h00
`define FIWL_RST_CTRL        1'b0
`define FIWL_RST_FLAGS       8'h00

// ************************************************************
// timing
// ************************************************************
`define FIWL_CLK_PERIOD_NS   4
`define FIWL_UV_DELAY_MS     25
`define FIWL_UV_DELAY_CYC    (`FIWL_UV_DELAY_MS * 1000000 / `FIWL_CLK_PERIOD_NS)

`endif

// ==== verilog/fiwl_pkg.sv ====
`default_nettype none
package fiwl_pkg;

  // ************************************************************
  // power state, one-hot
  // ************************************************************
  typedef enum logic [4:0] {
    PS_NORMAL  = 5'b00001,
    PS_STANDBY = 5'b00010,
    PS_OFF     = 5'b00100,
    PS_UV_WAIT = 5'b01000,
    PS_RESET   = 5'b10000
  } fiwl_pstate_t;

  // ************************************************************
  // whole state of the top module
  // ************************************************************
  typedef struct packed {
    logic [7:0]   flags;      // live fault status
    logic [7:0]   mask;       // interrupt mask
    logic         mirror_en;  // mirror regulator enable
    logic         unlocked;   // protected writes allowed
    logic         key_armed;  // first key byte seen
    fiwl_pstate_t pstate;     // power state
    logic [31:0]  uv_cnt;     // undervoltage wait counter, counts up
    logic         irq_n;      // interrupt pin level
    logic         pready;     // apb ready
    logic         pslverr;    // apb error
    logic [31:0]  prdata;     // apb read data
  } fiwl_state_t;

endpackage : fiwl_pkg
`default_nettype wire

// ==== verilog/fiwl_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module fiwl_sync #(
  parameter int         WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // raw and filtered levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ************************************************************
  // three stages plus filtered output
  // ************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] s1;   // metastable stage, read by s2 only
    logic [WIDTH-1:0] s2;   // second stage
    logic [WIDTH-1:0] s3;   // third stage
    logic [WIDTH-1:0] out;  // accepted level
  } fiwl_sync_t;

  fiwl_sync_t st_q;  // registered state
  fiwl_sync_t st_d;  // next state

  // shift and accept a bit once s2 and s3 agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, out: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.out;

endmodule : fiwl_sync
`default_nettype wire

// ==== verilog/fiwl_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fiwl_regs.svh"

// Functional notes
// - bit7 set while led supply over-voltage
// - bit6 set while six-volt rail unregulated
// - bit5 set while power request pin low
// - mirror fault: standby, clear mirror enable
// - mirror fault from slow inductor or pgood
// - undervoltage: bit3, clear enable, reset after 25ms
// - bit2 set while battery weak
// - thermal shutdown: bit1, standby, enable kept
// - shutdown flag held until die recovers
// - bit0 warm warning with recovery hold
// - mask bit one keeps pin released
// - mask resets to all zero
// - unlock only on consecutive key writes
// - writing 00 relocks protected registers
// - key register reads 00 locked, 01 unlocked
// - protected registers readable whether locked or not, in every state except reset
module fiwl_top #(
  parameter int          ADDR_W    = 12,
  parameter logic [31:0] UV_CYCLES = 32'(`FIWL_UV_DELAY_CYC)
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // detector levels, asynchronous
  input  wire logic              led_ovp_det,
  input  wire logic              rail6_unreg_det,
  input  wire logic              projector_power_request,
  input  wire logic              inductor_slow_det,
  input  wire logic              pgood_low_det,
  input  wire logic              battery_uv_det,
  input  wire logic              battery_weak_det,
  input  wire logic              die_shutdown_hot,
  input  wire logic              die_shutdown_cooled,
  input  wire logic              die_warm_hot,
  input  wire logic              die_warm_cooled,
  // device outputs
  output logic                   interrupt_request_n,
  output logic                   mirror_regulator_enable,
  output fiwl_pkg::fiwl_pstate_t power_state,
  output logic                   serial_port_enable
);

  // ************************************************************
  // helpers
  // ************************************************************

  // word-aligned index hit
  // low two address bits must be zero,
  // otherwise the access is unmapped
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : reg_hit

  // condition with recovery hold
  // set while hot, then held until the
  // cooled level returns; a die between
  // the two thresholds keeps the flag
  function automatic logic hold_flag(input logic cur, input logic thermal_warning_flag, input logic cooled);
    hold_flag = thermal_warning_flag | (cur & ~cooled);
  endfunction : hold_flag

  // ************************************************************
  // input synchronisation
  // ************************************************************
  // every detector is a raw analog level,
  // so each passes the same three-stage
  // filter before any flag sees it;
  // a lone glitch never reaches a flag
  localparam int NSYNC = 11;  // detector count

  logic [NSYNC-1:0] det_raw;  // raw detector vector
  logic [NSYNC-1:0] det_s;    // filtered detector vector

  assign det_raw = {led_ovp_det, rail6_unreg_det, projector_power_request,
                    inductor_slow_det, pgood_low_det, battery_uv_det,
                    battery_weak_det, die_shutdown_hot, die_shutdown_cooled,
                    die_warm_hot, die_warm_cooled};

  // cooled levels reset low; harmless,
  // the held flags reset clear as well
  // request pin idles high so no spurious off flag after reset
  fiwl_sync #(
    .WIDTH   (NSYNC),
    .RST_VAL (11'h100)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (det_raw),
    .sync_out (det_s)
  );

  // filtered detector names
  // order must match det_raw above
  logic s_ovp;       // led supply over-voltage
  logic s_rail6;     // six-volt rail out of regulation
  logic s_req;       // projector power request level
  logic s_slow;      // inductor current too slow
  logic s_pgood;     // regulator output below power-good
  logic s_uv;        // battery undervoltage
  logic s_weak;      // battery weak
  logic s_sd_hot;    // die over shutdown threshold
  logic s_sd_cool;   // die cooled from shutdown
  logic s_wm_hot;    // die over warm threshold
  logic s_wm_cool;   // die cooled from warm

  assign {s_ovp, s_rail6, s_req, s_slow, s_pgood, s_uv,
          s_weak, s_sd_hot, s_sd_cool, s_wm_hot, s_wm_cool} = det_s;

  // ************************************************************
  // state
  // ************************************************************
  // one packed struct holds every flop;
  // st_d is its next value, built below
  fiwl_pkg::fiwl_state_t st_q;  // registered state
  fiwl_pkg::fiwl_state_t st_d;  // next state

  // ************************************************************
  // next-state logic
  // ************************************************************
  // one pass builds flags, bus answer,
  // writes, enable and power state;
  // later blocks override earlier ones
  // where both touch the same field
  always_comb begin
    logic        acc;      // access phase, answered this edge
    logic        wr_done;  // write completes this edge
    logic        start;    // access phase, answer next edge
    logic        mapped;   // address hits a register
    logic        ser_on;   // serial port alive
    logic [31:0] rd;       // read mux
    logic        ctrl_wr;  // accepted enable write
    st_d    = st_q;
    acc     = psel & penable & st_q.pready;
    start   = psel & penable & ~st_q.pready;
    ser_on  = (st_q.pstate != fiwl_pkg::PS_RESET);
    wr_done = acc & pwrite & ser_on;
    // mapped: any of the five word addresses
    mapped  = reg_hit(paddr, `FIWL_IDX_STATUS) | reg_hit(paddr, `FIWL_IDX_MASK) |
              reg_hit(paddr, `FIWL_IDX_CTRL) | reg_hit(paddr, `FIWL_IDX_PSTATE) |
              reg_hit(paddr, `FIWL_IDX_KEY);
    // defaults so every path assigns
    rd      = 32'h0;
    ctrl_wr = 1'b0;

    // flags follow the filtered detectors
    // and lag their pins by about five edges
    // live status flags, no write path
    st_d.flags[`FIWL_BIT_LED_OVP]    = s_ovp;
    st_d.flags[`FIWL_BIT_RAIL6]      = s_rail6;
    st_d.flags[`FIWL_BIT_PROJ_REQ]   = ~s_req;
    st_d.flags[`FIWL_BIT_MIRROR_FLT] = s_slow | s_pgood;
    st_d.flags[`FIWL_BIT_BATT_UV]    = s_uv;
    st_d.flags[`FIWL_BIT_BATT_WEAK]  = s_weak;
    st_d.flags[`FIWL_BIT_THERM_SD]   =
      hold_flag(st_q.flags[`FIWL_BIT_THERM_SD], s_sd_hot, s_sd_cool);
    st_d.flags[`FIWL_BIT_THERM_WARN] =
      hold_flag(st_q.flags[`FIWL_BIT_THERM_WARN], s_wm_hot, s_wm_cool);

    // answer flop set by any access phase
    // not already answered, so pready is a one-cycle
    // pulse that repeats every other edge while
    // the request is still held by the master
    // two-phase answer: one wait cycle, then ready
    st_d.pready  = start;
    st_d.pslverr = 1'b0;
    st_d.prdata  = 32'h0;
    if (start) begin
      // read mux, every register readable regardless of lock
      // upper bits of every word read zero
      if (reg_hit(paddr, `FIWL_IDX_STATUS)) begin
        rd[7:0] = st_q.flags;
      end else if (reg_hit(paddr, `FIWL_IDX_MASK)) begin
        rd[7:0] = st_q.mask;
      end else if (reg_hit(paddr, `FIWL_IDX_CTRL)) begin
        rd[`FIWL_BIT_MIRROR_EN] = st_q.mirror_en;
      end else if (reg_hit(paddr, `FIWL_IDX_PSTATE)) begin
        rd[4:0] = st_q.pstate;
      end else if (reg_hit(paddr, `FIWL_IDX_KEY)) begin
        // lock state, not the bytes written
        rd[7:0] = st_q.unlocked ? `FIWL_KEY_RD_UNLOCKED : `FIWL_KEY_RD_LOCKED;
      end
      // writes are refused the same way
      // serial port down: error, no data
      st_d.pslverr = ~mapped | ~ser_on;
      st_d.prdata  = (mapped && ser_on && !pwrite) ? rd : 32'h0;
    end

    // a write lands only at the edge where
    // pready is seen high with the request
    // register writes at the completing edge
    if (wr_done) begin
      // any write other than a first key byte ends the sequence
      // reads in between leave it armed
      st_d.key_armed = 1'b0;
      if (reg_hit(paddr, `FIWL_IDX_MASK)) begin
        st_d.mask = pwdata[7:0];
      end else if (reg_hit(paddr, `FIWL_IDX_CTRL)) begin
        ctrl_wr = st_q.unlocked;
      end else if (reg_hit(paddr, `FIWL_IDX_KEY)) begin
        case (pwdata[7:0])
          `FIWL_KEY_FIRST: begin
            st_d.key_armed = 1'b1;
          end
          `FIWL_KEY_SECOND: begin
            if (st_q.key_armed) begin
              st_d.unlocked = 1'b1;
            end
          end
          `FIWL_KEY_LOCK: begin
            st_d.unlocked = 1'b0;
          end
          default: begin
            // any other byte cancels the sequence
            st_d.key_armed = 1'b0;
          end
        endcase
      end
    end

    // a write in the same cycle as a fault
    // is lost; software must write again
    // once the fault has gone
    // mirror enable: hardware clear beats software set
    if (ctrl_wr) begin
      st_d.mirror_en = pwdata[`FIWL_BIT_MIRROR_EN];
    end
    if (st_d.flags[`FIWL_BIT_MIRROR_FLT] || st_d.flags[`FIWL_BIT_BATT_UV]) begin
      st_d.mirror_en = 1'b0;
    end

    // undervoltage outranks everything, then
    // the request pin, then faults; standby
    // is the resting state after reset
    // every state leaves by a named branch
    // power state sequencing
    case (st_q.pstate)
      fiwl_pkg::PS_NORMAL, fiwl_pkg::PS_STANDBY, fiwl_pkg::PS_OFF: begin
        if (st_q.flags[`FIWL_BIT_BATT_UV]) begin
          st_d.pstate = fiwl_pkg::PS_UV_WAIT;
          st_d.uv_cnt = 32'h0;
        end else if (st_q.flags[`FIWL_BIT_PROJ_REQ]) begin
          st_d.pstate = fiwl_pkg::PS_OFF;
        end else if (st_q.flags[`FIWL_BIT_MIRROR_FLT] ||
                     st_q.flags[`FIWL_BIT_THERM_SD]) begin
          st_d.pstate = fiwl_pkg::PS_STANDBY;
        end else if (st_q.pstate == fiwl_pkg::PS_OFF) begin
          st_d.pstate = fiwl_pkg::PS_STANDBY;
        end else if (st_q.mirror_en) begin
          // standby leaves once faults are gone and enable is set
          // needs an unlocked enable write first
          st_d.pstate = fiwl_pkg::PS_NORMAL;
        end
      end
      fiwl_pkg::PS_UV_WAIT: begin
        // count runs up to the end once started
        // a brief dip still ends in reset
        if (st_q.uv_cnt >= UV_CYCLES - 32'h1) begin
          st_d.pstate = fiwl_pkg::PS_RESET;
          st_d.uv_cnt = 32'h0;
        end else begin
          st_d.uv_cnt = st_q.uv_cnt + 32'h1;
        end
      end
      fiwl_pkg::PS_RESET: begin
        // held with serial port off until battery recovers
        // key state dropped so a recovered part
        // always comes back locked
        st_d.unlocked  = 1'b0;
        st_d.key_armed = 1'b0;
        if (!st_q.flags[`FIWL_BIT_BATT_UV]) begin
          st_d.pstate = fiwl_pkg::PS_STANDBY;
        end
      end
      default: begin
        // illegal code: fall back to standby
        st_d.pstate = fiwl_pkg::PS_STANDBY;
      end
    endcase

    // next values keep the pin in step
    // with the flag that it reports
    // interrupt pin from next flags and mask
    st_d.irq_n = ~|(st_d.flags & ~st_d.mask);
  end

  // ************************************************************
  // state register
  // ************************************************************
  // asynchronous clear: comes up locked,
  // unmasked, in standby, pin released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.flags     <= `FIWL_RST_FLAGS;
      st_q.mask      <= `FIWL_RST_MASK;
      st_q.mirror_en <= `FIWL_RST_CTRL;
      st_q.unlocked  <= 1'b0;
      st_q.key_armed <= 1'b0;
      st_q.pstate    <= fiwl_pkg::PS_STANDBY;
      st_q.uv_cnt    <= 32'h0;
      st_q.irq_n     <= 1'b1;
      st_q.pready    <= 1'b0;
      st_q.pslverr   <= 1'b0;
      st_q.prdata    <= 32'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs, all from flops
  // ************************************************************
  assign pready                  = st_q.pready;
  assign prdata                  = st_q.prdata;
  assign pslverr                 = st_q.pslverr;
  assign interrupt_request_n     = st_q.irq_n;
  assign mirror_regulator_enable = st_q.mirror_en;
  assign power_state             = st_q.pstate;
  // serial port follows the reset state
  // and is down only while it is held
  assign serial_port_enable      = ~st_q.pstate[4];

endmodule : fiwl_top
`default_nettype wire

// ==== tb/fiwl_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// port checker for the fault, interrupt and lock block
// ************************************************************
module fiwl_checker #(
  parameter int          ADDR_W    = 12,
  parameter logic [31:0] UV_CYCLES = 32'h005F_5E10
) (
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic      [ADDR_W-1:0] paddr,
  input wire logic                   pready,
  input wire logic      [31:0]       prdata,
  input wire logic                   pslverr,
  // detectors
  input wire logic                   inductor_slow_det,
  input wire logic                   battery_uv_det,
  // device outputs
  input wire logic                   mirror_regulator_enable,
  input wire fiwl_pkg::fiwl_pstate_t power_state,
  input wire logic                   serial_port_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] uv_cnt_q; // cycles spent in the undervoltage wait
  // counts the undervoltage wait, cleared on leaving it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uv_cnt_q <= 32'h0;
    else if (power_state == fiwl_pkg::PS_UV_WAIT) uv_cnt_q <= uv_cnt_q + 32'h1;
    else uv_cnt_q <= 32'h0;
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("apb answer not after exactly one wait cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  a_err_unmapped: assert property (pready && !(paddr inside {12'h030, 12'h034, 12'h038,
    12'h03C, 12'h040}) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_reset: assert property ((power_state == fiwl_pkg::PS_RESET) [*3] ##0 pready |-> pslverr)
    else $error("access in reset state not refused");
  a_port_state: assert property (serial_port_enable == (power_state != fiwl_pkg::PS_RESET))
    else $error("serial port enable disagrees with state");
  a_uv_enable: assert property (battery_uv_det [*7] |-> !mirror_regulator_enable)
    else $error("undervoltage left mirror enable set");
  a_flt_enable: assert property (inductor_slow_det [*7] |-> !mirror_regulator_enable)
    else $error("mirror fault left mirror enable set");
  a_uv_stay: assert property (power_state == fiwl_pkg::PS_UV_WAIT |=>
    power_state inside {fiwl_pkg::PS_UV_WAIT, fiwl_pkg::PS_RESET})
    else $error("undervoltage wait left to wrong state");
  a_uv_bound: assert property (uv_cnt_q <= UV_CYCLES)
    else $error("undervoltage wait too long");
  a_uv_length: assert property ($fell(power_state == fiwl_pkg::PS_UV_WAIT) |->
    uv_cnt_q == UV_CYCLES)
    else $error("undervoltage wait length wrong");
endmodule : fiwl_checker
bind fiwl_top fiwl_checker #(.ADDR_W(ADDR_W), .UV_CYCLES(UV_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .inductor_slow_det(inductor_slow_det),
  .battery_uv_det(battery_uv_det), .mirror_regulator_enable(mirror_regulator_enable),
  .power_state(power_state), .serial_port_enable(serial_port_enable));
`default_nettype wire

// ==== tb/fiwl_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// host controller model: apb master
// ************************************************************
module fiwl_host (
  // clock
  input  wire logic        pclk,
  // apb request
  output var  logic        psel    = 1'b0,
  output var  logic        penable = 1'b0,
  output var  logic        pwrite  = 1'b0,
  output var  logic [11:0] paddr   = 12'h000,
  output var  logic [31:0] pwdata  = 32'h0,
  // apb answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // one transfer, held until pready is sampled high
  task automatic rw(input logic [11:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) tb_top.close_out(1);
  endtask : rw
  // two key bytes, nothing in between
  task automatic unlock;
    logic [31:0] q;
    logic        e;
    rw(12'h040, 1'b1, 32'h0000_00BA, q, e);
    rw(12'h040, 1'b1, 32'h0000_00BE, q, e);
  endtask : unlock
endmodule : fiwl_host
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fiwl_regs.svh"
module tb_top;
  // ************************************************************
  // signals
  // ************************************************************
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq_n, men, spe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  fiwl_pkg::fiwl_pstate_t ps;
  logic [5:0] det = 6'h00;  // ovp, rail6, slow, pgood, uv, weak
  logic       req = 1'b1;   // power request pin, high = on
  logic [1:0] thermal_warning_flag = 2'b00;  // bit1 shutdown, bit0 warm
  logic [1:0] cool = 2'b11; // recovered levels
  int mismatches = 0, total_checks = 0;
  int fb[4] = '{7, 6, 4, 2};
  int fd[4] = '{0, 1, 2, 5};
  always #2 pclk = ~pclk;
  fiwl_top #(.ADDR_W(12), .UV_CYCLES(32'h0000_0014)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .led_ovp_det(det[0]), .rail6_unreg_det(det[1]), .projector_power_request(req),
    .inductor_slow_det(det[2]), .pgood_low_det(det[3]), .battery_uv_det(det[4]),
    .battery_weak_det(det[5]), .die_shutdown_hot(thermal_warning_flag[1]), .die_shutdown_cooled(cool[1]),
    .die_warm_hot(thermal_warning_flag[0]), .die_warm_cooled(cool[0]), .interrupt_request_n(irq_n),
    .mirror_regulator_enable(men), .power_state(ps), .serial_port_enable(spe));
  fiwl_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out(input int hung);
    mismatches += hung;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic rg(input logic [11:0] a, input logic [31:0] exp);
    host.rw(a, 1'b0, 32'h0, rd, er);
    chk(rd, exp);
  endtask : rg
  task automatic wg(input logic [11:0] a, input logic [31:0] d);
    host.rw(a, 1'b1, d, rd, er);
  endtask : wg
  task automatic st(input fiwl_pkg::fiwl_pstate_t exp);
    chk(32'(ps), 32'(exp));
  endtask : st
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rg(12'h034, 32'h0);
    rg(12'h040, 32'h0);
    wg(12'h038, 32'h1);
    rg(12'h038, 32'h0);
    wg(12'h030, 32'hFF);
    rg(12'h030, 32'h0);
    chk(32'(irq_n), 32'h1);
    rg(12'h044, 32'h0);
    chk(32'(er), 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_flags;
    for (int i = 0; i < 4; i++) begin
      det[fd[i]] <= 1'b1;
      cyc(8);
      rg(12'h030, 32'h1 << fb[i]);
      chk(32'(irq_n), 32'h0);
      wg(12'h034, 32'h1 << fb[i]);
      cyc(2);
      chk(32'(irq_n), 32'h1);
      rg(12'h034, 32'h1 << fb[i]);
      wg(12'h034, 32'h0);
      det[fd[i]] <= 1'b0;
      cyc(8);
      rg(12'h030, 32'h0);
    end
    det[3] <= 1'b1;
    cyc(8);
    rg(12'h030, 32'h10);
    det[3] <= 1'b0;
    req <= 1'b0;
    cyc(8);
    rg(12'h030, 32'h20);
    st(fiwl_pkg::PS_OFF);
    req <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      thermal_warning_flag[b] <= 1'b1;
      cool[b] <= 1'b0;
      cyc(8);
      rg(12'h030, 32'h1 << b);
      thermal_warning_flag[b] <= 1'b0;
      cyc(8);
      rg(12'h030, 32'h1 << b);
      cool[b] <= 1'b1;
      cyc(8);
      rg(12'h030, 32'h0);
    end
    $display("test flags done");
  endtask : t_flags
  task automatic t_lock;
    host.unlock();
    rg(12'h040, 32'h1);
    wg(12'h038, 32'h1);
    rg(12'h038, 32'h1);
    cyc(8);
    chk(32'(men), 32'h1);
    det[2] <= 1'b1;
    cyc(8);
    chk(32'(men), 32'h0);
    st(fiwl_pkg::PS_STANDBY);
    wg(12'h038, 32'h1);
    rg(12'h038, 32'h0);
    det[2] <= 1'b0;
    cyc(8);
    wg(12'h038, 32'h1);
    cyc(8);
    st(fiwl_pkg::PS_NORMAL);
    thermal_warning_flag[1] <= 1'b1;
    cool[1] <= 1'b0;
    cyc(8);
    st(fiwl_pkg::PS_STANDBY);
    chk(32'(men), 32'h1);
    thermal_warning_flag[1] <= 1'b0;
    cool[1] <= 1'b1;
    wg(12'h040, 32'h0);
    rg(12'h040, 32'h0);
    wg(12'h038, 32'h0);
    rg(12'h038, 32'h1);
    wg(12'h040, 32'hBA);
    wg(12'h034, 32'h0);
    wg(12'h040, 32'hBE);
    rg(12'h040, 32'h0);
    $display("test lock done");
  endtask : t_lock
  task automatic t_uv;
    cyc(8);
    det[4] <= 1'b1;
    cyc(7);
    chk(32'(men), 32'h0);
    st(fiwl_pkg::PS_UV_WAIT);
    rg(12'h030, 32'h08);
    cyc(24);
    st(fiwl_pkg::PS_RESET);
    chk(32'(spe), 32'h0);
    rg(12'h040, 32'h0);
    chk(32'(er), 32'h1);
    det[4] <= 1'b0;
    cyc(8);
    st(fiwl_pkg::PS_STANDBY);
    rg(12'h040, 32'h0);
    $display("test undervoltage done");
  endtask : t_uv
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_lock();
    t_uv();
    close_out(0);
  end
endmodule : tb_top
`default_nettype wire
